// File: shared/bst_pkg.sv
// Purpose: Shared constants and types of the boundary-scan test port
// Assumes: Cell layout of the switch device's pin scan chain
// Notes:   Cell kinds and pin indices are worked out at elaboration

package bst_pkg;

    // ************************************************************
    // Register sizes and instruction codes
    // ************************************************************
    localparam int          ChainLen   = 268;
    localparam int          IrLen      = 4;
    localparam int          IdLen      = 32;
    localparam int          NumIn      = 106;
    localparam int          NumOut     = 81;
    localparam logic [3:0]  InstrExtest = 4'h0;
    localparam logic [3:0]  InstrSample = 4'h1;
    localparam logic [3:0]  InstrIdcode = 4'h2;
    localparam logic [3:0]  InstrHighz  = 4'h3;
    localparam logic [3:0]  InstrBypass = 4'hf;
    localparam logic [3:0]  IrCaptureVal = 4'h1;
    localparam logic [3:0]  IrResetVal   = InstrIdcode;

    // ************************************************************
    // Identification register layout (values arbitrary)
    // ************************************************************
    localparam int           IdRevLsb   = 28;
    localparam int           IdPartLsb  = 12;
    localparam int           IdVendLsb  = 1;
    localparam logic [3:0]   IdRevision = 4'h1;
    localparam logic [15:0]  IdPart     = 16'h5a5a;
    localparam logic [10:0]  IdVendor   = 11'h07e;
    localparam logic         IdPresent  = 1'h1;

    // ************************************************************
    // Chain layout
    // ************************************************************
    localparam int BidirFirst = 25;
    localparam int BidirLast  = 75;
    localparam int TxSegLen   = 32;
    localparam int TxSegLo[4] = '{84, 132, 180, 228};

    typedef enum logic [1:0] {CellIn, CellOut, CellCtl} bst_cell_kind_t;

    typedef enum logic [3:0] {
        TestLogicReset, RunTestIdle,
        SelectDrScan, CaptureDr, ShiftDr, Exit1Dr, PauseDr, Exit2Dr,
        UpdateDr,
        SelectIrScan, CaptureIr, ShiftIr, Exit1Ir, PauseIr, Exit2Ir,
        UpdateIr
    } bst_tap_state_t;

    typedef struct packed {
        logic tms;
        logic tdi;
    } bst_tap_in_t;

    typedef struct packed {
        logic [NumOut-1:0] level;
        logic [NumOut-1:0] enable;
    } bst_pad_drive_t;

    // Kind of scan cell at chain position i
    function automatic bst_cell_kind_t cellKind(int i);
        bst_cell_kind_t k;
        k = CellIn;
        if (i >= BidirFirst && i <= BidirLast) begin
            case ((i - BidirFirst) % 3)
                1:       k = CellOut;
                2:       k = CellCtl;
                default: k = CellIn;
            endcase
        end
        for (int s = 0; s < 4; s++) begin
            if (i >= TxSegLo[s] && i < TxSegLo[s] + TxSegLen) begin
                k = ((i - TxSegLo[s]) % 2 == 0) ? CellOut : CellCtl;
            end
        end
        return k;
    endfunction

    // Index of the pin within its kind, counted from cell 0
    function automatic int cellPin(int i);
        int n;
        n = 0;
        for (int j = 0; j < i; j++) begin
            if (cellKind(j) == cellKind(i)) begin
                n++;
            end
        end
        return n;
    endfunction

endpackage

// File: rtl/bst_test_port.sv
// Purpose: Boundary-scan test access port of the switch device
// Assumes: Tester drives test clock, mode select, data in, reset
// Notes:   Test logic runs on testClock; pad drive runs on clock
//
// Operation
// [R1] Mode select sampled each test clock rise
// [R2] Data input captured on test clock rise
// [R3] Data input feeds instruction or data register
// [R4] Data output changes on test clock fall
// [R5] Data output undriven unless shifting
// [R6] Undriven inputs read high via pull-ups
// [R7] Test reset clears controller and instruction
// [R8] Test clock independent of functional clocks
// [R9] Four-bit instruction loaded in shift-IR
// [R10] Instruction selects data register path
// [R11] Three data registers: chain, identification and bypass
// [R12] Bypass is one flip-flop stage
// [R13] Chain cells numbered 0 through 267
// [R14] Cell 0 shifts out first
// [R15] Control cell one enables its driver
// [R16] ID fields: revision, part, vendor positions
// [R17] ID bit 0 always one
// [R18] ID instruction loads fixed fields
// [R19] Code 0000 drives cells, selects chain
// [R20] Code 0010 selects identification register
// [R21] Code 0011 bypass and outputs high-Z
// [R22] Code 0001 samples pins, allows preload
// [R23] Code 1111 and undefined codes mean bypass
// [R24] Standard sixteen-state controller, reset on test reset
// [R25] Input cell per receive pin; output then control

`timescale 1ns/1ps
`default_nettype none

module bst_test_port
    import bst_pkg::*;
(
    // System clock domain
    input  wire logic           clock,
    input  wire logic           sys_rst,
    // Test access pins
    input  wire logic           testClock,
    input  wire logic           testRstN,
    input  wire bst_tap_in_t    tapIn,
    output logic                testDataOut,
    output logic                testDataOutOe,
    // Pads and core
    input  wire logic [NumIn-1:0] padIn,
    input  wire bst_pad_drive_t coreDrive,
    output bst_pad_drive_t      padDrive
);

    // ************************************************************
    // Test domain state
    // ************************************************************
    bst_tap_state_t         tapState_reg;
    bst_tap_state_t         tapState_next;
    logic [IrLen-1:0]       irShift_reg;
    logic [IrLen-1:0]       irCur_reg;
    logic                   extestFlag_reg;
    logic                   highzFlag_reg;
    logic [ChainLen-1:0]    chain_reg;
    logic [ChainLen-1:0]    update_reg;
    logic [IdLen-1:0]       id_reg;
    logic                   bypass_reg;
    logic [ChainLen-1:0]    obsMeta_reg;
    logic [ChainLen-1:0]    obsSync_reg;
    logic                   selChain;
    logic                   selId;
    logic                   serialOut;

    // ************************************************************
    // System domain state
    // ************************************************************
    logic [NumIn-1:0]       padMeta_reg;
    logic [NumIn-1:0]       padSync_reg;
    logic [ChainLen-1:0]    obs_reg;
    logic [ChainLen-1:0]    updMeta_reg;
    logic [ChainLen-1:0]    updSync_reg;
    logic [1:0]             modeMeta_reg;
    logic [1:0]             modeSync_reg;
    logic [ChainLen-1:0]    obsNext;
    bst_pad_drive_t         scanDrive;
    bst_pad_drive_t         padDrive_reg;

    // ************************************************************
    // Controller
    // ************************************************************
    // Undriven mode select floats high at the pad, which walks the
    // controller back to TestLogicReset [R6]
    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            tapState_reg <= TestLogicReset; // [R7] [R24]
        end else begin
            tapState_reg <= tapState_next; // [R1] [R8]
        end
    end

    always_comb begin
        tapState_next = tapState_reg;
        case (tapState_reg) // [R24]
            TestLogicReset: begin
                tapState_next = tapIn.tms ? TestLogicReset : RunTestIdle;
            end
            RunTestIdle: begin
                tapState_next = tapIn.tms ? SelectDrScan : RunTestIdle;
            end
            SelectDrScan: begin
                tapState_next = tapIn.tms ? SelectIrScan : CaptureDr;
            end
            CaptureDr: begin
                tapState_next = tapIn.tms ? Exit1Dr : ShiftDr;
            end
            ShiftDr: begin
                tapState_next = tapIn.tms ? Exit1Dr : ShiftDr;
            end
            Exit1Dr: begin
                tapState_next = tapIn.tms ? UpdateDr : PauseDr;
            end
            PauseDr: begin
                tapState_next = tapIn.tms ? Exit2Dr : PauseDr;
            end
            Exit2Dr: begin
                tapState_next = tapIn.tms ? UpdateDr : ShiftDr;
            end
            UpdateDr: begin
                tapState_next = tapIn.tms ? SelectDrScan : RunTestIdle;
            end
            SelectIrScan: begin
                tapState_next = tapIn.tms ? TestLogicReset : CaptureIr;
            end
            CaptureIr: begin
                tapState_next = tapIn.tms ? Exit1Ir : ShiftIr;
            end
            ShiftIr: begin
                tapState_next = tapIn.tms ? Exit1Ir : ShiftIr;
            end
            Exit1Ir: begin
                tapState_next = tapIn.tms ? UpdateIr : PauseIr;
            end
            PauseIr: begin
                tapState_next = tapIn.tms ? Exit2Ir : PauseIr;
            end
            Exit2Ir: begin
                tapState_next = tapIn.tms ? UpdateIr : ShiftIr;
            end
            UpdateIr: begin
                tapState_next = tapIn.tms ? SelectDrScan : RunTestIdle;
            end
            default: begin
                tapState_next = TestLogicReset;
            end
        endcase
    end

    // ************************************************************
    // Instruction register
    // ************************************************************
    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            irShift_reg <= IrResetVal; // [R7]
        end else if (tapState_reg == CaptureIr) begin
            irShift_reg <= IrCaptureVal;
        end else if (tapState_reg == ShiftIr) begin
            irShift_reg <= {tapIn.tdi, irShift_reg[IrLen-1:1]}; // [R2] [R3] [R9]
        end
    end

    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            irCur_reg      <= IrResetVal; // [R7]
            extestFlag_reg <= 1'h0;
            highzFlag_reg  <= 1'h0;
        end else if (tapState_reg == TestLogicReset) begin
            irCur_reg      <= IrResetVal;
            extestFlag_reg <= 1'h0;
            highzFlag_reg  <= 1'h0;
        end else if (tapState_reg == UpdateIr) begin
            irCur_reg      <= irShift_reg; // [R9]
            extestFlag_reg <= (irShift_reg == InstrExtest); // [R19]
            highzFlag_reg  <= (irShift_reg == InstrHighz); // [R21]
        end
    end

    // Path select: anything but chain or ID codes goes to bypass
    always_comb begin
        selChain = (irCur_reg == InstrExtest) ||
                   (irCur_reg == InstrSample); // [R10] [R19] [R22]
        selId    = (irCur_reg == InstrIdcode); // [R20]
    end

    // ************************************************************
    // Data registers
    // ************************************************************
    // Pin and driver levels brought over from the system domain
    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            obsMeta_reg <= '0;
            obsSync_reg <= '0;
        end else begin
            obsMeta_reg <= obs_reg;
            obsSync_reg <= obsMeta_reg;
        end
    end

    // Cell 0 sits at the output end of the chain [R13] [R14]
    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            chain_reg <= '0;
        end else if (selChain && tapState_reg == CaptureDr) begin
            chain_reg <= obsSync_reg; // [R22]
        end else if (selChain && tapState_reg == ShiftDr) begin
            chain_reg <= {tapIn.tdi, chain_reg[ChainLen-1:1]}; // [R3] [R11]
        end
    end

    // Update stage also takes preload data under the sample code
    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            update_reg <= '0;
        end else if (selChain && tapState_reg == UpdateDr) begin
            update_reg <= chain_reg; // [R19] [R22]
        end
    end

    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            id_reg <= '0;
        end else if (selId && tapState_reg == CaptureDr) begin
            id_reg <= {IdRevision, IdPart, IdVendor, IdPresent}; // [R16] [R17] [R18]
        end else if (selId && tapState_reg == ShiftDr) begin
            id_reg <= {tapIn.tdi, id_reg[IdLen-1:1]};
        end
    end

    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            bypass_reg <= 1'h0;
        end else if (!selChain && !selId && tapState_reg == CaptureDr) begin
            bypass_reg <= 1'h0;
        end else if (!selChain && !selId && tapState_reg == ShiftDr) begin
            bypass_reg <= tapIn.tdi; // [R12] [R21] [R23]
        end
    end

    always_comb begin
        if (selChain) begin
            serialOut = chain_reg[0]; // [R14]
        end else if (selId) begin
            serialOut = id_reg[0];
        end else begin
            serialOut = bypass_reg; // [R23]
        end
    end

    // ************************************************************
    // Test data output
    // ************************************************************
    always_ff @(negedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            testDataOut   <= 1'h0;
            testDataOutOe <= 1'h0;
        end else begin
            testDataOut   <= (tapState_reg == ShiftIr) ?
                             irShift_reg[0] : serialOut; // [R4]
            testDataOutOe <= (tapState_reg == ShiftIr) ||
                             (tapState_reg == ShiftDr); // [R5]
        end
    end

    // ************************************************************
    // System domain: pad sampling and drive
    // ************************************************************
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            padMeta_reg <= '0;
            padSync_reg <= '0;
        end else begin
            padMeta_reg <= padIn;
            padSync_reg <= padMeta_reg;
        end
    end

    // Cell roles follow the chain layout [R25]
    for (genvar i = 0; i < ChainLen; i++) begin : gCell
        if (cellKind(i) == CellIn) begin : gIn
            assign obsNext[i] = padSync_reg[cellPin(i)];
        end else if (cellKind(i) == CellOut) begin : gOut
            assign obsNext[i] = padDrive_reg.level[cellPin(i)];
            assign scanDrive.level[cellPin(i)]  = updSync_reg[i];
            assign scanDrive.enable[cellPin(i)] = updSync_reg[i+1]; // [R15] [R25]
        end else begin : gCtl
            assign obsNext[i] = padDrive_reg.enable[cellPin(i)];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            obs_reg <= '0;
        end else begin
            obs_reg <= obsNext;
        end
    end

    // Update stage and mode are static while in use; bits are
    // synchronised side by side and settle within two clocks
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            updMeta_reg  <= '0;
            updSync_reg  <= '0;
            modeMeta_reg <= 2'h0;
            modeSync_reg <= 2'h0;
        end else begin
            updMeta_reg  <= update_reg; // [R8]
            updSync_reg  <= updMeta_reg;
            modeMeta_reg <= {highzFlag_reg, extestFlag_reg};
            modeSync_reg <= modeMeta_reg;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            padDrive_reg <= '0;
        end else if (modeSync_reg[1]) begin
            padDrive_reg <= '0; // [R21]
        end else if (modeSync_reg[0]) begin
            padDrive_reg <= scanDrive; // [R19]
        end else begin
            padDrive_reg <= coreDrive;
        end
    end

    assign padDrive = padDrive_reg;

endmodule

`default_nettype wire

// File: verification/bst_tester.sv
// Purpose: Scan tester model driving the test access pins
// Assumes: Bench runs the test clock freely
// Notes:   Idle data line sits high like a pull-up; mode select idles low
`timescale 1ns/1ps
`default_nettype none
module bst_tester
    import bst_pkg::*;
(
    // Test link
    input  wire logic   testClock,
    output bst_tap_in_t tapIn,
    output logic        testRstN
);
    // ************************************************************
    // Pin sequencing
    // ************************************************************
    initial begin
        tapIn    = '{tms: 1'b1, tdi: 1'b1};
        testRstN = 1'b0;
    end

    task automatic step(input logic m, input logic d);
        @(posedge testClock);
        tapIn <= '{tms: m, tdi: d};
    endtask

    // Reset pulse, five mode-select ones, then idle
    task automatic reset();
        testRstN <= 1'b0;
        repeat (8) step(1'b1, 1'b1);
        testRstN <= 1'b1;
        repeat (5) step(1'b1, 1'b1);
        repeat (2) step(1'b0, 1'b1);
    endtask

    // One scan of n bits from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [299:0] d);
        step(1'b1, 1'b1);
        if (ir) step(1'b1, 1'b1);
        repeat (2) step(1'b0, 1'b1);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i]);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
endmodule
`default_nettype wire

// File: verification/bst_test_port_chk.sv
// Purpose: Port-level checks of the boundary-scan test port
// Assumes: Sees only the top module's ports
// Notes:   Test-domain checks other than the falling-edge check start from a controller reset
`timescale 1ns/1ps
`default_nettype none
module bst_test_port_chk
    import bst_pkg::*;
(
    // System side
    input  wire logic            clock,
    input  wire logic            sys_rst,
    // Test link
    input  wire logic            testClock,
    input  wire logic            testRstN,
    input  wire bst_tap_in_t     tapIn,
    input  wire logic            testDataOut,
    input  wire logic            testDataOutOe,
    // Pads
    input  wire logic [NumIn-1:0] padIn,
    input  wire bst_pad_drive_t  coreDrive,
    input  wire bst_pad_drive_t  padDrive
);
    // ************************************************************
    // Helper and assertions
    // ************************************************************
    logic [1:0] lastOut_reg;

    always_ff @(posedge testClock or negedge testRstN) begin
        if (!testRstN) begin
            lastOut_reg <= 2'h0;
        end else begin
            lastOut_reg <= {testDataOut, testDataOutOe};
        end
    end

    tdo_fall_edge_a: assert property (
        @(negedge testClock) disable iff (!testRstN)
        {testDataOut, testDataOutOe} == lastOut_reg)
        else $error("serial output moved on a rising edge");
    tlr_idle_a: assert property (
        @(posedge testClock) disable iff (!testRstN)
        tapIn.tms [*5] |=> !testDataOutOe)
        else $error("output driven after controller reset");
    rti_idle_a: assert property (
        @(posedge testClock) disable iff (!testRstN)
        tapIn.tms [*5] ##1 !tapIn.tms [*2] |=> !testDataOutOe)
        else $error("output driven while idle");
    dr_first_a: assert property (
        @(posedge testClock) disable iff (!testRstN)
        tapIn.tms [*5] ##1 !tapIn.tms [*2] ##1 tapIn.tms ##1 !tapIn.tms [*2]
        |=> testDataOutOe && testDataOut)
        else $error("first identification bit wrong");
    ir_first_a: assert property (
        @(posedge testClock) disable iff (!testRstN)
        tapIn.tms [*5] ##1 !tapIn.tms [*2] ##1 tapIn.tms [*2] ##1
        !tapIn.tms [*2] |=> testDataOutOe && testDataOut == IrCaptureVal[0])
        else $error("first instruction bit wrong");
    ir_len_a: assert property (
        @(posedge testClock) disable iff (!testRstN)
        tapIn.tms [*5] ##1 !tapIn.tms [*2] ##1 tapIn.tms [*2] ##1
        !tapIn.tms [*5] ##1 tapIn.tms |-> testDataOutOe ##1 !testDataOutOe)
        else $error("instruction shift length wrong");
    trst_idle_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !testRstN |-> !testDataOutOe)
        else $error("output driven during test reset");
    pad_follow_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !testRstN [*6] |-> padDrive == $past(coreDrive))
        else $error("pads not following core during test reset");
    pad_reset_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) |-> padDrive == '0)
        else $error("pad drive not cleared by system reset");
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench of the boundary-scan test port
// Assumes: Tester model drives the test link
// Notes:   Serial results are checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin \
    bad_count++; $display("wrong value at %0t: got %0h want %0h", \
    $time, got, want); end end
module testbench
    import bst_pkg::*;
;
    // ************************************************************
    // Signals, clocks and instances
    // ************************************************************
    logic             clock;
    logic             sys_rst;
    logic             testClock;
    logic             testRstN;
    logic             testDataOut;
    logic             testDataOutOe;
    bst_tap_in_t      tapIn;
    logic [NumIn-1:0] padIn;
    bst_pad_drive_t   coreDrive;
    bst_pad_drive_t   padDrive;
    int               bad_count = 0;
    int               cmp_count = 0;
    logic [1:0]       expQ[$];
    logic [299:0]     lastIn;
    int               segLo[4] = '{84, 132, 180, 228};
    localparam logic [31:0] IdVal = {IdRevision, IdPart, IdVendor, IdPresent};

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        testClock = 1'b0;
        #1.3;
        forever #3 testClock = ~testClock;
    end

    bst_test_port u_bst_test_port (.clock(clock), .sys_rst(sys_rst),
        .testClock(testClock), .testRstN(testRstN), .tapIn(tapIn),
        .testDataOut(testDataOut), .testDataOutOe(testDataOutOe),
        .padIn(padIn), .coreDrive(coreDrive), .padDrive(padDrive));
    bst_tester u_bst_tester (.testClock(testClock), .tapIn(tapIn),
        .testRstN(testRstN));

    // Serial output watcher
    always @(posedge testClock) begin
        logic [1:0] e;
        if (testDataOutOe === 1'b1) begin
            if (expQ.size() == 0) begin
                bad_count++;
                $display("wrong value at %0t: unexpected serial bit", $time);
            end else begin
                e = expQ.pop_front();
                if (e[1]) `CHK(testDataOut, e[0])
            end
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    function automatic logic [299:0] rnd();
        logic [299:0] r;
        for (int i = 0; i < 10; i++) r = {r[267:0], $urandom()};
        return r;
    endfunction

    task automatic irScan(input logic [3:0] code);
        for (int i = 0; i < IrLen; i++) expQ.push_back({1'b1, IrCaptureVal[i]});
        u_bst_tester.scan(1'b1, IrLen, {296'h0, code});
        `CHK(expQ.size(), 0)
    endtask

    // Scan len cells plus eight extra bits that must come straight through
    task automatic drScan(input int len, input logic [299:0] cap,
                          input logic [299:0] care);
        lastIn = rnd();
        for (int i = 0; i < len + 8; i++)
            expQ.push_back(i < len ? {care[i], cap[i]} : {1'b1, lastIn[i - len]});
        u_bst_tester.scan(1'b0, len + 8, lastIn);
        `CHK(expQ.size(), 0)
    endtask

    // Expected capture, and pad drive from the last shifted pattern
    task automatic chainMap(input logic ex, output logic [299:0] cap,
                            output bst_pad_drive_t ext);
        int nI;
        int nO;
        int nC;
        int k;
        nI = 0;
        nO = 0;
        nC = 0;
        cap = '0;
        ext = '0;
        for (int i = 0; i < ChainLen; i++) begin
            k = (i >= 25 && i <= 75) ? (i - 25) % 3 : 0;
            for (int s = 0; s < 4; s++)
                if (i >= segLo[s] && i < segLo[s] + 32) k = (i % 2) + 1;
            if (k == 0) begin
                cap[i] = padIn[nI];
                nI++;
            end else if (k == 1) begin
                cap[i] = ex ? lastIn[i + 8] : coreDrive.level[nO];
                ext.level[nO] = lastIn[i + 8];
                nO++;
            end else begin
                cap[i] = ex ? lastIn[i + 8] : coreDrive.enable[nC];
                ext.enable[nC] = lastIn[i + 8];
                nC++;
            end
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        logic [299:0]   cap;
        bst_pad_drive_t ext;
        logic [3:0]     codes[7];
        sys_rst = 1'b1;
        padIn = '0;
        coreDrive = '0;
        codes = '{InstrIdcode, InstrHighz, InstrBypass, 4'h5, 4'h9,
                  InstrSample, InstrExtest};
        void'($urandom(32'h9145_755f));
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        cap = rnd();
        padIn <= cap[267:162];
        coreDrive <= cap[161:0];
        u_bst_tester.reset();
        drScan(IdLen, {268'h0, IdVal}, {300{1'b1}});
        $display("test identification after reset done");
        foreach (codes[j]) begin
            chainMap(codes[j] == InstrExtest, cap, ext);
            irScan(codes[j]);
            repeat (8) @(posedge clock);
            @(negedge clock);
            if (codes[j] == InstrHighz) `CHK(padDrive, bst_pad_drive_t'(0))
            else if (codes[j] == InstrExtest) `CHK(padDrive, ext)
            else `CHK(padDrive, coreDrive)
            if (codes[j] == InstrIdcode) drScan(IdLen, {268'h0, IdVal}, {300{1'b1}});
            else if (codes[j] <= InstrSample) drScan(ChainLen, cap,
                {300{1'b1}});
            else drScan(1, 300'h0, 300'h1);
            $display("test code %h done", codes[j]);
        end
        u_bst_tester.reset();
        `CHK(padDrive, coreDrive)
        irScan(InstrBypass);
        drScan(1, 300'h0, 300'h1);
        $display("test mid-run reset done");
        stop_test();
    end

    initial begin
        #100_000;
        bad_count++;
        $display("wrong value at %0t: run timed out", $time);
        stop_test();
    end
endmodule

bind bst_test_port bst_test_port_chk u_bst_test_port_chk (.clock(clock),
    .sys_rst(sys_rst), .testClock(testClock), .testRstN(testRstN),
    .tapIn(tapIn), .testDataOut(testDataOut), .testDataOutOe(testDataOutOe),
    .padIn(padIn), .coreDrive(coreDrive), .padDrive(padDrive));
`default_nettype wire
